// *** write_guard_cfg.svh ***
// constants for the write guard and status logic
`ifndef WRITE_GUARD_CFG_SVH
`define WRITE_GUARD_CFG_SVH

// write_guard_status field positions
`define LOCK_BIT 7
`define END_SEL_BIT 5
`define GUARD_HI 4
`define GUARD_LO 2
`define LATCH_BIT 1
`define PENDING_BIT 0
// checksum_status field positions
`define SUSP_BIT 4
`define ABORT_BIT 3
// reset values
`define GUARD_STATUS_RESET 8'h00
`define CHECKSUM_STATUS_RESET 8'h00
// array geometry
`define ARRAY_LAST 21'h1FFFFF
`define SMALLEST_BLOCK 21'h008000
`define GUARD_NONE 3'h0
`define GUARD_ALL 3'h7
// any-register addresses
`define AR_SR1_NV 24'h000000
`define AR_SR1_V 24'h070000
`define AR_SR2_NV 24'h000001
`define AR_SR2_V 24'h070001
// opcodes
`define OP_LATCH_CLEAR 8'h04
`define OP_STATUS_WRITE 8'h01
`define OP_SPECIAL_WRITE 8'h42
`define OP_AR_WRITE 8'h71
`define OP_SN_WRITE 8'hC2
`define OP_LATCH_SET 8'h06
`define OP_SR1_READ 8'h05
`define OP_SR2_READ 8'h07
`define OP_AR_READ 8'h65
`define OP_MEM_WRITE 8'h02
`define OP_SUSPEND 8'hB0
`define OP_RESUME 8'h30
`define OP_RST_ARM 8'h66
`define OP_RST 8'h99
// frame bit counts
`define OPCODE_END 6'd8
`define SR_DATA_END 6'd16
`define ADDR_END 6'd32
`define FRAME_MAX 6'd40

`endif

// *** write_guard_pkg.sv ***
// types shared by the write guard and status logic
package write_guard_pkg;
    typedef enum logic [3:0] {
        CMD_NONE, CMD_LATCH_SET, CMD_LATCH_CLEAR, CMD_STATUS_WRITE, CMD_SPECIAL_WRITE,
        CMD_AR_WRITE, CMD_SN_WRITE, CMD_SR1_READ, CMD_SR2_READ, CMD_AR_READ,
        CMD_MEM_WRITE, CMD_SUSPEND, CMD_RESUME, CMD_RST_ARM, CMD_RST
    } cmd_t;

    typedef enum logic {
        RST_IDLE, RST_ARMED
    } soft_reset_state_t;

    // guard fields of write_guard_status
    typedef struct packed {
        logic register_lock;
        logic array_end_select;
        logic [2:0] guard_code;
    } guard_cfg_t;

    // one captured frame, opcode in the top byte
    typedef struct packed {
        logic [39:0] bits;
        logic [5:0] nbits;
    } frame_t;
endpackage

// *** write_guard_status_logic.sv ***
// write guard, write latch and checksum status logic of the serial memory
//
// Functional notes
// - array_end_select picks top or bottom as the start of the guarded range.
// - end select 0, codes 1..6 guard top 1/64 up to half, ending 0x1FFFFF.
// - end select 1, codes 1..6 guard bottom 1/64 up to half from zero.
// - guard code 000 guards nothing, 111 guards the whole array.
// - array writes into the guarded range never change the array.
// - with write_latch clear every array and register write is refused.
// - beyond a clear write_latch, register writes blocked only when register_lock is 1 and guard pin low.
// - write_latch is set only by the latch set command.
// - latch clear and register, special, serial writes clear write_latch at frame end.
// - array writes leave write_latch set at frame end.
// - write_latch clears on power-on and every reset.
// - work_pending reads 1 only while a checksum calculation runs.
// - while pending only status reads, suspend and soft reset are taken.
// - work_pending clears on power-on and every reset.
// - checksum_status returned for its read command or any-register read at both addresses.
// - checksum_status bits 7,6,5,2,1,0 read as zero.
// - suspend command during a running checksum sets the suspended flag.
// - resume command clears the suspended flag; host cannot write it.
// - suspended flag clears on power-on, hardware and software reset.
// - aborted flag shows 1 after a checksum abort, read only.
// - register_lock with guard pin low makes register changing commands ignored.
// - aborted flag clears on a good checksum start and on every reset.
`timescale 1ns/1ps
`include "write_guard_cfg.svh"

module write_guard_status_logic (
    // system clock and reset
    input wire logic mclk,
    input wire logic reset,
    // serial link, framed by chip select
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic mosi,
    // pins
    input wire logic guard_pin_n,
    input wire logic hw_reset_n,
    // checksum engine
    input wire logic crc_running,
    input wire logic crc_start_ok,
    input wire logic crc_abort_evt,
    output logic crc_suspend_req,
    output logic crc_resume_req,
    output logic soft_reset_pulse,
    // array write gate
    output logic array_write_grant,
    output logic array_write_refused,
    output logic [20:0] array_write_addr,
    // register read answer
    output logic read_valid,
    output logic [7:0] read_data,
    // register contents
    output logic [7:0] write_guard_status,
    output logic [7:0] checksum_status
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------

    // change counts only once the second and third stage agree
    function automatic logic filtered(input logic prev, input logic s2, input logic s3);
        filtered = (s2 == s3) ? s2 : prev;
    endfunction

    function automatic write_guard_pkg::cmd_t decode_cmd(input logic [7:0] op);
        case (op)
            `OP_LATCH_SET: decode_cmd = write_guard_pkg::CMD_LATCH_SET;
            `OP_LATCH_CLEAR: decode_cmd = write_guard_pkg::CMD_LATCH_CLEAR;
            `OP_STATUS_WRITE: decode_cmd = write_guard_pkg::CMD_STATUS_WRITE;
            `OP_SPECIAL_WRITE: decode_cmd = write_guard_pkg::CMD_SPECIAL_WRITE;
            `OP_AR_WRITE: decode_cmd = write_guard_pkg::CMD_AR_WRITE;
            `OP_SN_WRITE: decode_cmd = write_guard_pkg::CMD_SN_WRITE;
            `OP_SR1_READ: decode_cmd = write_guard_pkg::CMD_SR1_READ;
            `OP_SR2_READ: decode_cmd = write_guard_pkg::CMD_SR2_READ;
            `OP_AR_READ: decode_cmd = write_guard_pkg::CMD_AR_READ;
            `OP_MEM_WRITE: decode_cmd = write_guard_pkg::CMD_MEM_WRITE;
            `OP_SUSPEND: decode_cmd = write_guard_pkg::CMD_SUSPEND;
            `OP_RESUME: decode_cmd = write_guard_pkg::CMD_RESUME;
            `OP_RST_ARM: decode_cmd = write_guard_pkg::CMD_RST_ARM;
            `OP_RST: decode_cmd = write_guard_pkg::CMD_RST;
            default: decode_cmd = write_guard_pkg::CMD_NONE;
        endcase
    endfunction

    // guarded range: size doubles with each code step from the smallest block
    function automatic logic in_guard(input logic [20:0] addr, input write_guard_pkg::guard_cfg_t cfg);
        logic [20:0] size;
        size = `SMALLEST_BLOCK << (cfg.guard_code - 3'h1);
        if (cfg.guard_code == `GUARD_NONE)
            in_guard = 1'b0;
        else if (cfg.guard_code == `GUARD_ALL)
            in_guard = 1'b1;
        else if (cfg.array_end_select)
            in_guard = (addr < size);
        else
            in_guard = (addr > (`ARRAY_LAST - size));
    endfunction

    // ------------------------------------------------------------
    // link domain capture
    // ------------------------------------------------------------

    logic [5:0] bit_cnt;
    logic [5:0] link_count;
    logic [39:0] link_shift;

    // chip select high clears the count; the link clock may stop between frames
    always_ff @(posedge link_clk or posedge cs_n)
    begin
        if (cs_n)
            bit_cnt <= 6'h00;
        else if (bit_cnt != `FRAME_MAX)
            bit_cnt <= bit_cnt + 6'h01;
    end

    // bits and count are held after the frame until the next one starts
    always_ff @(posedge link_clk or posedge reset)
    begin
        if (reset)
        begin
            link_shift <= 40'h00_0000_0000;
            link_count <= 6'h00;
        end
        else if (bit_cnt != `FRAME_MAX)
        begin
            link_shift <= {link_shift[38:0], mosi};
            link_count <= bit_cnt + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------

    logic [2:0] cs_sync;
    logic [2:0] guard_sync;
    logic [2:0] hwrst_sync;
    logic cs_level;
    logic cs_prev;
    logic guard_level;
    logic hwrst_level;

    // three stages each; levels idle high, matching the pins at rest
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cs_sync <= 3'h7;
            guard_sync <= 3'h7;
            hwrst_sync <= 3'h7;
            cs_level <= 1'b1;
            cs_prev <= 1'b1;
            guard_level <= 1'b1;
            hwrst_level <= 1'b1;
        end
        else
        begin
            cs_sync <= {cs_sync[1:0], cs_n};
            guard_sync <= {guard_sync[1:0], guard_pin_n};
            hwrst_sync <= {hwrst_sync[1:0], hw_reset_n};
            cs_level <= filtered(cs_level, cs_sync[1], cs_sync[2]);
            cs_prev <= cs_level;
            guard_level <= filtered(guard_level, guard_sync[1], guard_sync[2]);
            hwrst_level <= filtered(hwrst_level, hwrst_sync[1], hwrst_sync[2]);
        end
    end

    // ------------------------------------------------------------
    // frame decode at chip select rise
    // ------------------------------------------------------------

    write_guard_pkg::guard_cfg_t guard_cfg;
    write_guard_pkg::frame_t frame;
    write_guard_pkg::cmd_t cmd;
    write_guard_pkg::soft_reset_state_t rst_state;
    logic write_latch;
    logic work_pending;
    logic suspended;
    logic aborted;
    logic frame_end;
    logic [23:0] frame_addr;
    logic sr1_addr;
    logic sr2_addr;
    logic busy_ok;
    logic accept;
    logic reg_write_ok;
    logic sr1_write;
    logic [7:0] sr1_data;
    logic vol_clear;

    // link words are quiet here: the frame is over and its clock has stopped
    assign frame_end = cs_level & ~cs_prev;
    assign frame.nbits = link_count;
    assign frame.bits = link_shift << (`FRAME_MAX - link_count);
    assign frame_addr = frame.bits[31:8];
    assign sr1_addr = (frame_addr == `AR_SR1_NV) || (frame_addr == `AR_SR1_V);
    assign sr2_addr = (frame_addr == `AR_SR2_NV) || (frame_addr == `AR_SR2_V);
    assign vol_clear = soft_reset_pulse | ~hwrst_level;

    // command class, the register lock and the busy filter
    always_comb
    begin
        cmd = write_guard_pkg::CMD_NONE;
        if (frame.nbits >= `OPCODE_END)
            cmd = decode_cmd(frame.bits[39:32]);
        busy_ok = (cmd == write_guard_pkg::CMD_SR1_READ) || (cmd == write_guard_pkg::CMD_SR2_READ)
            || (cmd == write_guard_pkg::CMD_SUSPEND) || (cmd == write_guard_pkg::CMD_RST_ARM)
            || (cmd == write_guard_pkg::CMD_RST)
            || ((cmd == write_guard_pkg::CMD_AR_READ) && (sr1_addr || sr2_addr));
        accept = frame_end && (!work_pending || busy_ok);
        reg_write_ok = write_latch && !(guard_cfg.register_lock && !guard_level);
        sr1_write = 1'b0;
        sr1_data = frame.bits[31:24];
        if ((cmd == write_guard_pkg::CMD_STATUS_WRITE) && (frame.nbits >= `SR_DATA_END))
            sr1_write = 1'b1;
        else if ((cmd == write_guard_pkg::CMD_AR_WRITE) && (frame.nbits == `FRAME_MAX) && sr1_addr)
        begin
            sr1_write = 1'b1;
            sr1_data = frame.bits[7:0];
        end
    end

    // ------------------------------------------------------------
    // write latch
    // ------------------------------------------------------------

    // a locked register write is ignored whole, so its latch stays as it was
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            write_latch <= 1'b0;
        else if (vol_clear)
            write_latch <= 1'b0;
        else if (accept && (cmd == write_guard_pkg::CMD_LATCH_SET))
            write_latch <= 1'b1;
        else if (accept && ((cmd == write_guard_pkg::CMD_LATCH_CLEAR)
            || (cmd == write_guard_pkg::CMD_SPECIAL_WRITE) || (cmd == write_guard_pkg::CMD_SN_WRITE)
            || (((cmd == write_guard_pkg::CMD_STATUS_WRITE) || (cmd == write_guard_pkg::CMD_AR_WRITE))
            && reg_write_ok)))
            write_latch <= 1'b0;
    end

    // ------------------------------------------------------------
    // guard fields
    // ------------------------------------------------------------

    // reset image held as a sized value, so its fields can be picked apart
    localparam logic [7:0] guard_reset = `GUARD_STATUS_RESET;

    // nonvolatile copies live elsewhere; the reset value stands in for them
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            guard_cfg <= write_guard_pkg::guard_cfg_t'({guard_reset[`LOCK_BIT],
                guard_reset[`END_SEL_BIT:`GUARD_LO]});
        else if (accept && sr1_write && reg_write_ok)
            guard_cfg <= write_guard_pkg::guard_cfg_t'({sr1_data[`LOCK_BIT], sr1_data[`END_SEL_BIT:`GUARD_LO]});
    end

    // ------------------------------------------------------------
    // array write gate
    // ------------------------------------------------------------

    // refused writes only raise the refused pulse; no flag moves
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            array_write_grant <= 1'b0;
            array_write_refused <= 1'b0;
            array_write_addr <= 21'h000000;
        end
        else
        begin
            array_write_grant <= 1'b0;
            array_write_refused <= 1'b0;
            if (accept && (cmd == write_guard_pkg::CMD_MEM_WRITE) && (frame.nbits >= `ADDR_END))
            begin
                array_write_addr <= frame_addr[20:0];
                if (write_latch && !in_guard(frame_addr[20:0], guard_cfg))
                    array_write_grant <= 1'b1;
                else
                    array_write_refused <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // checksum status
    // ------------------------------------------------------------

    // work_pending mirrors only the running calculation
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            work_pending <= 1'b0;
        else
            work_pending <= crc_running & ~vol_clear;
    end

    // suspend flag, with the engine requests
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            suspended <= 1'b0;
            crc_suspend_req <= 1'b0;
            crc_resume_req <= 1'b0;
        end
        else
        begin
            crc_suspend_req <= accept && (cmd == write_guard_pkg::CMD_SUSPEND) && work_pending;
            crc_resume_req <= accept && (cmd == write_guard_pkg::CMD_RESUME);
            if (vol_clear)
                suspended <= 1'b0;
            else if (accept && (cmd == write_guard_pkg::CMD_SUSPEND) && work_pending)
                suspended <= 1'b1;
            else if (accept && (cmd == write_guard_pkg::CMD_RESUME))
                suspended <= 1'b0;
        end
    end

    // abort flag: a new abort wins over a clearing start in the same cycle
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            aborted <= 1'b0;
        else if (vol_clear)
            aborted <= 1'b0;
        else if (crc_abort_evt)
            aborted <= 1'b1;
        else if (crc_start_ok)
            aborted <= 1'b0;
    end

    // ------------------------------------------------------------
    // software reset pair
    // ------------------------------------------------------------

    // the arm must be the accepted frame right before the reset frame
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            rst_state <= write_guard_pkg::RST_IDLE;
            soft_reset_pulse <= 1'b0;
        end
        else
        begin
            soft_reset_pulse <= 1'b0;
            if (accept)
            begin
                case (rst_state)
                    write_guard_pkg::RST_IDLE:
                        if (cmd == write_guard_pkg::CMD_RST_ARM)
                            rst_state <= write_guard_pkg::RST_ARMED;
                    write_guard_pkg::RST_ARMED:
                    begin
                        soft_reset_pulse <= (cmd == write_guard_pkg::CMD_RST);
                        rst_state <= (cmd == write_guard_pkg::CMD_RST_ARM) ? write_guard_pkg::RST_ARMED
                            : write_guard_pkg::RST_IDLE;
                    end
                    default: rst_state <= write_guard_pkg::RST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // register contents and read answer
    // ------------------------------------------------------------

    assign write_guard_status = {guard_cfg.register_lock, 1'b0, guard_cfg.array_end_select,
        guard_cfg.guard_code, write_latch, work_pending};
    assign checksum_status = {3'h0, suspended, aborted, 3'h0};

    // status reads answer one cycle after the frame ends
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            read_valid <= 1'b0;
            read_data <= `CHECKSUM_STATUS_RESET;
        end
        else
        begin
            read_valid <= 1'b0;
            if (accept && ((cmd == write_guard_pkg::CMD_SR1_READ)
                || ((cmd == write_guard_pkg::CMD_AR_READ) && sr1_addr && (frame.nbits >= `ADDR_END))))
            begin
                read_valid <= 1'b1;
                read_data <= write_guard_status;
            end
            else if (accept && ((cmd == write_guard_pkg::CMD_SR2_READ)
                || ((cmd == write_guard_pkg::CMD_AR_READ) && sr2_addr && (frame.nbits >= `ADDR_END))))
            begin
                read_valid <= 1'b1;
                read_data <= checksum_status;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    latch_set_only_a: assert property ($rose(write_latch) |-> $past(accept && cmd == write_guard_pkg::CMD_LATCH_SET))
        else $error("write latch set by other command");
    latch_clear_a: assert property (accept && cmd == write_guard_pkg::CMD_LATCH_CLEAR |=> !write_latch)
        else $error("latch clear did not clear");
    latch_keep_a: assert property (accept && cmd == write_guard_pkg::CMD_MEM_WRITE && write_latch && !vol_clear
        |=> write_latch)
        else $error("array write dropped latch");
    guard_refuse_a: assert property (array_write_grant |-> !in_guard(array_write_addr, guard_cfg))
        else $error("write granted inside guard");
    latch_gate_a: assert property (accept && cmd == write_guard_pkg::CMD_MEM_WRITE && !write_latch
        |=> !array_write_grant)
        else $error("write granted without latch");
    full_guard_a: assert property (array_write_grant |-> guard_cfg.guard_code != `GUARD_ALL)
        else $error("write granted under full guard");
    top_range_a: assert property (array_write_grant && !guard_cfg.array_end_select && guard_cfg.guard_code == 3'h1
        |-> array_write_addr <= `ARRAY_LAST - `SMALLEST_BLOCK)
        else $error("top block not guarded");
    bottom_range_a: assert property (array_write_grant && guard_cfg.array_end_select && guard_cfg.guard_code == 3'h1
        |-> array_write_addr >= `SMALLEST_BLOCK)
        else $error("bottom block not guarded");
    reg_lock_a: assert property (accept && sr1_write && guard_cfg.register_lock && !guard_level
        |=> $stable(guard_cfg) && $stable(write_latch))
        else $error("locked register changed");
    pending_cause_a: assert property (work_pending |-> $past(crc_running))
        else $error("pending without checksum");
    busy_ignore_a: assert property (frame_end && work_pending && cmd == write_guard_pkg::CMD_LATCH_SET && !vol_clear
        |=> $stable(write_latch))
        else $error("command taken while pending");
    reset_flags_a: assert property (vol_clear |=> !write_latch && !suspended && !aborted && !work_pending)
        else $error("reset left volatile flag");
    suspend_set_a: assert property (accept && cmd == write_guard_pkg::CMD_SUSPEND && work_pending && !vol_clear
        |=> suspended ##1 suspended || (vol_clear || crc_resume_req))
        else $error("suspend flag not set");
    abort_flag_a: assert property (crc_abort_evt && !vol_clear |=> aborted)
        else $error("abort flag missed");
    sr2_read_a: assert property (accept && cmd == write_guard_pkg::CMD_SR2_READ
        |=> read_valid && read_data == $past(checksum_status))
        else $error("status two read wrong");

    latch_then_write_c: cover property (accept && cmd == write_guard_pkg::CMD_LATCH_SET ##[1:400] array_write_grant);
    suspend_c: cover property ($rose(suspended));
    soft_reset_c: cover property (soft_reset_pulse);
    lock_refusal_c: cover property (accept && sr1_write && guard_cfg.register_lock && !guard_level);
endmodule

// *** host_spi_model.sv ***
// host controller model that frames commands onto the serial link
`timescale 1ns/1ps
module host_spi_model (
    // serial link toward the device
    output logic link_clk,
    output logic cs_n,
    output logic mosi
);
    initial
    begin
        link_clk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // one frame, msb first; link clock stands still outside it
    // status is never polled across a reset, fixed waits are used
    task automatic send(input logic [39:0] bits, input int n);
        cs_n = 1'b0;
        #30;
        for (int i = 39; i > 39 - n; i--)
        begin
            mosi = bits[i];
            #62.5 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
        end
        #30 cs_n = 1'b1;
        #200; // gap well past the 6 cycle minimum and the answer delay
    endtask
endmodule

// *** write_guard_status_logic_test.sv ***
// self-checking bench for the write guard and status logic
`timescale 1ns/1ps
module write_guard_status_logic_test;
    logic mclk = 1'b0, reset = 1'b1, guard_pin_n = 1'b1, hw_reset_n = 1'b1;
    logic crc_running = 1'b0, crc_start_ok = 1'b0, crc_abort_evt = 1'b0;
    logic link_clk, cs_n, mosi, crc_suspend_req, crc_resume_req, soft_reset_pulse;
    logic array_write_grant, array_write_refused, read_valid, got_grant, got_ref;
    logic [20:0] array_write_addr;
    logic [2:0] pulses;
    logic [7:0] read_data, write_guard_status, checksum_status, last_read;
    int errors = 0, comparisons = 0, cycles = 0;
    // rows: end select, guard code, address, grant expected; boundaries of the code 1 and 6 ranges, then codes 0 and 7
    logic [25:0] rows [10] = '{{1'b0, 3'h1, 21'h1F7FFF, 1'b1}, {1'b0, 3'h1, 21'h1F8000, 1'b0},
        {1'b0, 3'h6, 21'h0FFFFF, 1'b1}, {1'b0, 3'h6, 21'h100000, 1'b0}, {1'b1, 3'h1, 21'h007FFF, 1'b0},
        {1'b1, 3'h1, 21'h008000, 1'b1}, {1'b1, 3'h6, 21'h0FFFFF, 1'b0}, {1'b1, 3'h6, 21'h100000, 1'b1},
        {1'b0, 3'h0, 21'h1FFFFF, 1'b1}, {1'b1, 3'h7, 21'h000000, 1'b0}};
    always #4 mclk = ~mclk;
    host_spi_model host (.link_clk, .cs_n, .mosi);
    write_guard_status_logic DUT (.mclk, .reset, .link_clk, .cs_n, .mosi, .guard_pin_n, .hw_reset_n,
        .crc_running, .crc_start_ok, .crc_abort_evt, .crc_suspend_req, .crc_resume_req, .soft_reset_pulse,
        .array_write_grant, .array_write_refused, .array_write_addr, .read_valid, .read_data,
        .write_guard_status, .checksum_status);
    // answers are one-cycle pulses, so hold them until the next frame
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (!cs_n) {got_grant, got_ref, pulses, last_read} <= 13'h0FF; // flags cleared, last_read set to FF while a frame is sent
        if (array_write_grant) got_grant <= 1'b1;
        if (array_write_refused) got_ref <= 1'b1;
        if (read_valid) last_read <= read_data;
        if (crc_suspend_req) pulses[2] <= 1'b1;
        if (crc_resume_req) pulses[1] <= 1'b1;
        if (soft_reset_pulse) pulses[0] <= 1'b1;
        if (cycles == 40000)
        begin
            errors++;
            print_verdict();
        end
    end
    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [31:0] rest, input int n);
        host.send({op, rest}, n);
    endtask
    task automatic pulse_abort();
        @(posedge mclk) crc_abort_evt <= 1'b1;
        @(posedge mclk) crc_abort_evt <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        cmd(8'h01, 32'h1C00_0000, 16);
        check(write_guard_status, 8'h00);
        cmd(8'h02, 32'h0, 32);
        check({got_grant, got_ref}, 8'h01);
        foreach (rows[i])
        begin
            cmd(8'h06, 32'h0, 8);
            cmd(8'h01, {2'b00, rows[i][25:22], 26'h0}, 16);
            check(write_guard_status, {2'b00, rows[i][25:22], 2'b00});
            cmd(8'h06, 32'h0, 8);
            cmd(8'h02, {3'h0, rows[i][21:1], 8'h00}, 32);
            check({got_grant, got_ref}, {6'h0, rows[i][0], !rows[i][0]});
            check(array_write_addr, rows[i][21:1]);
            check(write_guard_status[1], 8'h01);
        end
        // the other latch clearing commands but the special write
        cmd(8'h06, 32'h0, 8);
        cmd(8'h71, 32'h0700_0000, 40);
        check(write_guard_status, 8'h00);
        cmd(8'h06, 32'h0, 8);
        cmd(8'h04, 32'h0, 8);
        check(write_guard_status, 8'h00);
        cmd(8'h06, 32'h0, 8);
        cmd(8'hC2, 32'h0, 8);
        check(write_guard_status, 8'h00);
        // register lock only bites with the guard pin low
        cmd(8'h06, 32'h0, 8);
        cmd(8'h01, 32'h8000_0000, 16);
        @(posedge mclk) guard_pin_n <= 1'b0;
        cmd(8'h06, 32'h0, 8);
        cmd(8'h01, 32'h0, 16);
        check(write_guard_status, 8'h82);
        @(posedge mclk) guard_pin_n <= 1'b1;
        cmd(8'h01, 32'h0, 16);
        check(write_guard_status, 8'h00);
        // busy: latch set is ignored, status reads and suspend get through
        @(posedge mclk) crc_running <= 1'b1;
        cmd(8'h06, 32'h0, 8);
        check(write_guard_status, 8'h01);
        cmd(8'hB0, 32'h0, 8);
        check(checksum_status, 8'h10);
        check(pulses, 3'h4);
        cmd(8'h05, 32'h0, 8);
        check(last_read, 8'h01);
        cmd(8'h07, 32'h0, 8);
        check(last_read, 8'h10);
        cmd(8'h65, 32'h0700_0100, 32);
        check(last_read, 8'h10);
        @(posedge mclk) crc_running <= 1'b0;
        cmd(8'h30, 32'h0, 8);
        check(checksum_status, 8'h00);
        check(pulses, 3'h2);
        pulse_abort();
        check(checksum_status, 8'h08);
        @(posedge mclk) crc_start_ok <= 1'b1;
        @(posedge mclk) crc_start_ok <= 1'b0;
        repeat (2) @(posedge mclk);
        check(checksum_status, 8'h00);
        // hardware reset pin, then the soft reset pair
        @(posedge mclk) crc_running <= 1'b1;
        cmd(8'hB0, 32'h0, 8);
        @(posedge mclk) crc_running <= 1'b0;
        cmd(8'h06, 32'h0, 8);
        pulse_abort();
        @(posedge mclk) hw_reset_n <= 1'b0;
        repeat (10) @(posedge mclk) hw_reset_n <= 1'b0;
        @(posedge mclk) hw_reset_n <= 1'b1;
        check({write_guard_status[1], checksum_status[4:3]}, 8'h00);
        cmd(8'h06, 32'h0, 8);
        pulse_abort();
        cmd(8'h66, 32'h0, 8);
        cmd(8'h99, 32'h0, 8);
        check(write_guard_status, 8'h00);
        check(checksum_status, 8'h00);
        check(pulses, 3'h1);
        // power-on reset again in mid-run
        cmd(8'h06, 32'h0, 8);
        @(posedge mclk) reset <= 1'b1;
        @(posedge mclk) reset <= 1'b0;
        check(write_guard_status, 8'h00);
        print_verdict();
    end
endmodule
